// ==== hw/protect_cmd_host.v ====
// Host sequencer issuing sector-protection command sequences to the flash.
// Behaviour
// - Mode entry is three writes; third to AAA with mode byte 40/60/C0/50/E0.
// - Entry starts with AA to AAA then 55 to 555.
// - Lock register: program is A0 then value; read once at address 00.
// - Leave mode with 90 then 00 to any address.
// - Single F0 write leaves mode and returns to array read.
// - Password program: A0 then the byte to its address 00-07.
// - Password read: eight reads at full addresses 00 to 07.
// - Unlock: 25, 03, eight bytes at 00-07, then 29, eleven writes.
// - Persistent bit set: A0 then 00 to an address in the sector.
// - Freeze: A0 then 00 sets it; one read returns it on bit zero.
// - Volatile bit: A0 then sector write; 00 sets, 01 clears.
`timescale 1ns/10ps
module protect_cmd_host
#(
    parameter AW = 23
)
(
    input wire clk,
    input wire nrst,
    input wire req,
    input wire [3:0] op,
    input wire [7:0] mode_code,
    input wire [AW-1:0] sector_select_address,
    input wire [7:0] wr_value,
    input wire [63:0] password_byte_value,
    output wire ready,
    output reg done_q,
    output reg [7:0] rd_value_q,
    output reg [63:0] password_rd_q,
    output reg protected_q,
    output wire [AW-1:0] flash_addr,
    output wire [7:0] flash_data_out,
    output wire flash_data_oe_n,
    input wire [7:0] flash_data_in,
    output wire flash_ce_n,
    output wire flash_we_n,
    output wire flash_oe_n
);
`include "protect_cmd_regs.vh"
// ==========================================================================
// Command sequencer
localparam S_IDLE = 3'b001;
localparam S_CYCLE = 3'b010;
localparam S_WAIT = 3'b100;
reg [2:0] st_q;
reg [3:0] op_q;
reg [3:0] idx_q;
reg [3:0] last_q;
reg [7:0] mode_q;
reg [AW-1:0] sa_q;
reg [7:0] val_q;
reg [63:0] pwd_q;
reg cyc_start;
reg cyc_read;
reg [AW-1:0] cyc_addr;
reg [7:0] cyc_data;
wire cyc_done;
wire [7:0] cyc_rdata;
assign ready = st_q[0];
// ==========================================================================
// Per-cycle address and data selection
function [AW-1:0] low_addr;
    input [11:0] a;
    begin
        low_addr = {{(AW-12){1'b0}}, a};
    end
endfunction
always @*
begin
    cyc_read = 1'b0;
    cyc_addr = {AW{1'b0}};
    cyc_data = 8'h00;
    case (op_q)
        `OP_ENTER:
        begin
            case (idx_q)
                4'h0:
                begin
                    cyc_addr = low_addr(`UNLOCK1_ADDR);
                    cyc_data = `UNLOCK1_DATA;
                end
                4'h1:
                begin
                    cyc_addr = low_addr(`UNLOCK2_ADDR);
                    cyc_data = `UNLOCK2_DATA;
                end
                default:
                begin
                    cyc_addr = low_addr(`ENTRY_ADDR);
                    cyc_data = mode_q;
                end
            endcase
        end
        `OP_EXIT:
            cyc_data = (idx_q == 4'h0) ? `CMD_EXIT1 : `CMD_EXIT2;
        `OP_RESET:
            cyc_data = `CMD_RESET;
        `OP_LOCK_READ, `OP_FREEZE_READ:
            cyc_read = 1'b1;
        `OP_PWD_READ:
        begin
            cyc_read = 1'b1;
            cyc_addr = {{(AW-4){1'b0}}, idx_q};
        end
        `OP_PWD_PROG:
        begin
            cyc_addr = {{(AW-4){1'b0}}, 1'b0, sa_q[2:0]};
            cyc_data = (idx_q == 4'h0) ? `CMD_PROGRAM : val_q;
            if (idx_q == 4'h0)
                cyc_addr = {AW{1'b0}};
        end
        `OP_PWD_UNLOCK:
        begin
            if (idx_q == 4'h0)
                cyc_data = `CMD_UNLOCK1;
            else if (idx_q == 4'h1)
                cyc_data = `CMD_UNLOCK2;
            else if (idx_q == 4'hA)
                cyc_data = `CMD_CONFIRM;
            else
            begin
                cyc_addr = {{(AW-3){1'b0}}, idx_q[2:0] - 3'h2};
                cyc_data = pwd_q[8*(idx_q-4'h2) +: 8];
            end
        end
        `OP_PERSIST_ERASE:
        begin
            cyc_data = (idx_q == 4'h0) ? `CMD_ERASE1 : `CMD_ERASE2;
            cyc_addr = low_addr(`ADDR_ZERO);
        end
        `OP_STATUS_READ:
        begin
            cyc_read = 1'b1;
            cyc_addr = sa_q;
        end
        `OP_LOCK_PROG:
            cyc_data = (idx_q == 4'h0) ? `CMD_PROGRAM : val_q;
        `OP_PERSIST_SET, `OP_FREEZE_SET, `OP_VOL_SET:
        begin
            cyc_data = (idx_q == 4'h0) ? `CMD_PROGRAM : `DATA_SET;
            cyc_addr = sa_q;
        end
        `OP_VOL_CLEAR:
        begin
            cyc_data = (idx_q == 4'h0) ? `CMD_PROGRAM : `DATA_CLEAR;
            cyc_addr = sa_q;
        end
        default:
            cyc_data = `CMD_RESET;
    endcase
end
// ==========================================================================
// Index of the last cycle for each operation (cycle count minus one)
reg [3:0] last_d;
always @*
begin
    case (op)
        `OP_ENTER: last_d = 4'h2;
        `OP_EXIT: last_d = 4'h1;
        `OP_RESET: last_d = 4'h0;
        `OP_LOCK_PROG: last_d = 4'h1;
        `OP_LOCK_READ: last_d = 4'h0;
        `OP_PWD_PROG: last_d = 4'h1;
        `OP_PWD_READ: last_d = 4'h7;
        `OP_PWD_UNLOCK: last_d = 4'hA;
        `OP_PERSIST_SET: last_d = 4'h1;
        `OP_PERSIST_ERASE: last_d = 4'h1;
        `OP_STATUS_READ: last_d = 4'h0;
        `OP_FREEZE_SET: last_d = 4'h1;
        `OP_FREEZE_READ: last_d = 4'h0;
        `OP_VOL_SET: last_d = 4'h1;
        `OP_VOL_CLEAR: last_d = 4'h1;
        default: last_d = 4'h0;
    endcase
end
// ==========================================================================
// Sequencer state
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        st_q <= S_IDLE;
        op_q <= `OP_RESET;
        idx_q <= 4'h0;
        last_q <= 4'h0;
        mode_q <= 8'h00;
        sa_q <= {AW{1'b0}};
        val_q <= 8'h00;
        pwd_q <= 64'h0;
        done_q <= 1'b0;
        cyc_start <= 1'b0;
    end
    else
    begin
        done_q <= 1'b0;
        cyc_start <= 1'b0;
        case (st_q)
            S_IDLE:
            begin
                if (req)
                begin
                    op_q <= op;
                    mode_q <= mode_code;
                    sa_q <= sector_select_address;
                    val_q <= wr_value;
                    pwd_q <= password_byte_value;
                    last_q <= last_d;
                    idx_q <= 4'h0;
                    cyc_start <= 1'b1;
                    st_q <= S_CYCLE;
                end
            end
            S_CYCLE:
                st_q <= S_WAIT;
            S_WAIT:
            begin
                if (cyc_done)
                begin
                    if (idx_q == last_q)
                    begin
                        done_q <= 1'b1;
                        st_q <= S_IDLE;
                    end
                    else
                    begin
                        idx_q <= idx_q + 4'h1;
                        cyc_start <= 1'b1;
                        st_q <= S_CYCLE;
                    end
                end
            end
            default:
                st_q <= S_IDLE;
        endcase
    end
end
// ==========================================================================
// Read result capture
localparam N_PWD = 8;
wire rd_take;
wire pwd_read_op;
wire [7:0] lane_sel;
wire [63:0] password_rd_d;
assign rd_take = st_q[2] && cyc_done && cyc_read;
assign pwd_read_op = (op_q == `OP_PWD_READ);
assign lane_sel = 8'h01 << idx_q[2:0];
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        rd_value_q <= 8'h00;
        password_rd_q <= 64'h0;
        protected_q <= 1'b0;
    end
    else if (rd_take)
    begin
        rd_value_q <= cyc_rdata;
        password_rd_q <= password_rd_d;
        protected_q <= !cyc_rdata[0];
    end
end
// ==========================================================================
// Password read lanes, one per byte
genvar g;
generate
    for (g = 0; g < N_PWD; g = g + 1)
    begin : g_pwd_lane
        assign password_rd_d[8*g +: 8] = (pwd_read_op && lane_sel[g]) ?
            cyc_rdata : password_rd_q[8*g +: 8];
    end
endgenerate
// ==========================================================================
// Bus cycle engine
flash_bus_cycle #(.AW(AW)) u_cycle
(
    .clk(clk),
    .nrst(nrst),
    .start(cyc_start),
    .is_read(cyc_read),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .done(cyc_done),
    .rdata_q(cyc_rdata),
    .fa_q(flash_addr),
    .fd_out_q(flash_data_out),
    .fd_oe_n_q(flash_data_oe_n),
    .fce_n_q(flash_ce_n),
    .fwe_n_q(flash_we_n),
    .foe_n_q(flash_oe_n),
    .fd_in(flash_data_in)
);
endmodule // protect_cmd_host

// ==== inc/protect_cmd_regs.vh ====
// Command codes, addresses and timing counts for the protection sequencer.
`ifndef PROTECT_CMD_REGS_VH
`define PROTECT_CMD_REGS_VH
// ==========================================================================
// Unlock and entry cycles
`define UNLOCK1_ADDR 12'hAAA
`define UNLOCK1_DATA 8'hAA
`define UNLOCK2_ADDR 12'h555
`define UNLOCK2_DATA 8'h55
`define ENTRY_ADDR 12'hAAA
`define MODE_LOCK_REG 8'h40
`define MODE_PASSWORD 8'h60
`define MODE_PERSIST 8'hC0
`define MODE_FREEZE 8'h50
`define MODE_VOLATILE 8'hE0
// ==========================================================================
// In-mode command codes
`define CMD_PROGRAM 8'hA0
`define CMD_EXIT1 8'h90
`define CMD_EXIT2 8'h00
`define CMD_RESET 8'hF0
`define CMD_ERASE1 8'h80
`define CMD_ERASE2 8'h30
`define CMD_UNLOCK1 8'h25
`define CMD_UNLOCK2 8'h03
`define CMD_CONFIRM 8'h29
`define DATA_SET 8'h00
`define DATA_CLEAR 8'h01
`define ADDR_ZERO 12'h000
// ==========================================================================
// Operation codes on the user port
`define OP_ENTER 4'h0
`define OP_EXIT 4'h1
`define OP_RESET 4'h2
`define OP_LOCK_PROG 4'h3
`define OP_LOCK_READ 4'h4
`define OP_PWD_PROG 4'h5
`define OP_PWD_READ 4'h6
`define OP_PWD_UNLOCK 4'h7
`define OP_PERSIST_SET 4'h8
`define OP_PERSIST_ERASE 4'h9
`define OP_STATUS_READ 4'hA
`define OP_FREEZE_SET 4'hB
`define OP_FREEZE_READ 4'hC
`define OP_VOL_SET 4'hD
`define OP_VOL_CLEAR 4'hE
// ==========================================================================
// Bus cycle timing in clock cycles (50 ns each)
`define CYC_SETUP 2'h1
`define CYC_STROBE 2'h2
`define CYC_HOLD 2'h1
`endif

// ==== hw/flash_bus_cycle.v ====
// One write or read cycle on the parallel flash bus.
`timescale 1ns/10ps
module flash_bus_cycle
#(
    parameter AW = 23
)
(
    input wire clk,
    input wire nrst,
    input wire start,
    input wire is_read,
    input wire [AW-1:0] addr,
    input wire [7:0] wdata,
    output wire done,
    output reg [7:0] rdata_q,
    output reg [AW-1:0] fa_q,
    output reg [7:0] fd_out_q,
    output reg fd_oe_n_q,
    output reg fce_n_q,
    output reg fwe_n_q,
    output reg foe_n_q,
    input wire [7:0] fd_in
);
`include "protect_cmd_regs.vh"
// ==========================================================================
// Phase sequencer
localparam S_IDLE = 4'b0001;
localparam S_SETUP = 4'b0010;
localparam S_STROBE = 4'b0100;
localparam S_HOLD = 4'b1000;
reg [3:0] st_q;
reg [1:0] cnt_q;
reg rd_q;
assign done = st_q[3] && (cnt_q == 2'h0);
always @(posedge clk or negedge nrst)
begin
    if (!nrst)
    begin
        st_q <= S_IDLE;
        cnt_q <= 2'h0;
        rd_q <= 1'b0;
        rdata_q <= 8'h00;
        fa_q <= {AW{1'b0}};
        fd_out_q <= 8'h00;
        fd_oe_n_q <= 1'b1;
        fce_n_q <= 1'b1;
        fwe_n_q <= 1'b1;
        foe_n_q <= 1'b1;
    end
    else
    begin
        case (st_q)
            S_IDLE:
            begin
                if (start)
                begin
                    fa_q <= addr;
                    fd_out_q <= wdata;
                    rd_q <= is_read;
                    fd_oe_n_q <= is_read;
                    fce_n_q <= 1'b0;
                    cnt_q <= `CYC_SETUP;
                    st_q <= S_SETUP;
                end
            end
            S_SETUP:
            begin
                if (cnt_q == 2'h1)
                begin
                    fwe_n_q <= rd_q;
                    foe_n_q <= !rd_q;
                    cnt_q <= `CYC_STROBE;
                    st_q <= S_STROBE;
                end
                else
                    cnt_q <= cnt_q - 2'h1;
            end
            S_STROBE:
            begin
                if (cnt_q == 2'h1)
                begin
                    if (rd_q)
                        rdata_q <= fd_in;
                    fwe_n_q <= 1'b1;
                    foe_n_q <= 1'b1;
                    cnt_q <= `CYC_HOLD;
                    st_q <= S_HOLD;
                end
                else
                    cnt_q <= cnt_q - 2'h1;
            end
            S_HOLD:
            begin
                if (cnt_q == 2'h0)
                begin
                    fce_n_q <= 1'b1;
                    fd_oe_n_q <= 1'b1;
                    st_q <= S_IDLE;
                end
                else
                    cnt_q <= cnt_q - 2'h1;
            end
            default:
                st_q <= S_IDLE;
        endcase
    end
end
endmodule // flash_bus_cycle

// ==== verif/protect_cmd_host_asserts.sv ====
// Checker for the protection command sequencer bus ports.
`timescale 1ns/10ps
`include "protect_cmd_regs.vh"
module protect_cmd_host_asserts
#(
    parameter AW = 23
)
(
    input wire clk,
    input wire nrst,
    input wire req,
    input wire [3:0] op,
    input wire ready,
    input wire done_q,
    input wire [AW-1:0] flash_addr,
    input wire [7:0] flash_data_out,
    input wire flash_data_oe_n,
    input wire flash_ce_n,
    input wire flash_we_n,
    input wire flash_oe_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // ======================================================================
    // Bus cycle shape.
    chk_strobe_excl:
    assert property (!(!flash_we_n && !flash_oe_n)) else $error("both strobes low");
    chk_write_drive:
    assert property (!flash_we_n |-> !flash_ce_n && !flash_data_oe_n)
        else $error("write strobe without drive");
    chk_read_release:
    assert property (!flash_oe_n |-> !flash_ce_n && flash_data_oe_n)
        else $error("read strobe while driving");
    chk_strobe_width:
    assert property ($fell(flash_we_n) |-> ##1 !flash_we_n ##1 flash_we_n)
        else $error("write strobe width wrong");
    chk_write_stable:
    assert property (!flash_we_n ##1 !flash_we_n |->
        $stable(flash_addr) && $stable(flash_data_out))
        else $error("write address or data moved");
    // ======================================================================
    // Commands launched by requests.
    chk_entry_first:
    assert property (req && ready && op == `OP_ENTER |-> ##[1:8]
        (!flash_we_n && flash_data_out == `UNLOCK1_DATA &&
        flash_addr[11:0] == `UNLOCK1_ADDR)) else $error("no unlock write");
    chk_exit_first:
    assert property (req && ready && op == `OP_EXIT |-> ##[1:8]
        (!flash_we_n && flash_data_out == `CMD_EXIT1))
        else $error("no exit write");
    chk_reset_write:
    assert property (req && ready && op == `OP_RESET |-> ##[1:8]
        (!flash_we_n && flash_data_out == `CMD_RESET))
        else $error("no reset write");
    chk_done_pulse:
    assert property (done_q |=> !done_q) else $error("done longer than one");
    cover property (req && ready && op == `OP_PWD_UNLOCK);
    cover property (req && ready && op == `OP_STATUS_READ);
    cover property (req && ready && op == `OP_RESET);
endmodule // protect_cmd_host_asserts
bind protect_cmd_host protect_cmd_host_asserts #(.AW(AW)) chk_u (.clk(clk),
    .nrst(nrst), .req(req), .op(op), .ready(ready), .done_q(done_q),
    .flash_addr(flash_addr), .flash_data_out(flash_data_out),
    .flash_data_oe_n(flash_data_oe_n), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));

// ==== verif/flash_device_model.sv ====
// Behavioural flash device answering protection command sequences.
`timescale 1ns/10ps
module flash_device_model
#(
    parameter AW = 23
)
(
    input wire [AW-1:0] flash_addr,
    input wire [7:0] flash_data_out,
    input wire flash_ce_n,
    input wire flash_we_n,
    input wire flash_oe_n,
    output logic [7:0] flash_data_in
);
    logic [7:0] mode = 8'h00;
    logic [7:0] lock = 8'h00;
    logic [7:0] pwd [8];
    logic [255:0] persistent_protect_bit = '0;
    logic [255:0] volatile_protect_bit = '0;
    logic frz = 1'b0;
    logic [1:0] pend = 2'h0;
    logic [1:0] unl = 2'h0;
    logic ex = 1'b0;
    logic [3:0] ucnt = 4'h0;
    logic [7:0] rd;
    wire [7:0] sec = flash_addr[AW-1:AW-8];
    wire [11:0] a = flash_addr[11:0];
    wire [7:0] d = flash_data_out;
    // ======================================================================
    // Write decode at the end of each write strobe.
    always @(posedge flash_we_n)
    begin
        if (!flash_ce_n)
        begin
            if (d == 8'hF0)
            begin
                mode = 8'h00;
                pend = 2'h0;
                ex = 1'b0;
                ucnt = 4'h0;
            end
            else if (mode == 8'h00)
            begin
                if (unl == 2'h2 && a == 12'hAAA)
                    mode = d;
                unl = (a == 12'hAAA && d == 8'hAA) ? 2'h1 :
                    (unl == 2'h1 && a == 12'h555 && d == 8'h55) ? 2'h2 : 2'h0;
            end
            else if (ucnt != 4'h0)
                ucnt = ucnt - 4'h1;
            else if (pend == 2'h1)
            begin
                case (mode)
                    8'h40: lock = d;
                    8'h60: pwd[flash_addr[2:0]] = d;
                    8'hC0: persistent_protect_bit[sec] = 1'b1;
                    8'h50: frz = 1'b1;
                    default: volatile_protect_bit[sec] = (d[0] == 1'b0);
                endcase
                pend = 2'h0;
            end
            else if (pend == 2'h2)
            begin
                persistent_protect_bit = '1;
                persistent_protect_bit = '0;
                pend = 2'h0;
            end
            else if (d == 8'hA0)
                pend = 2'h1;
            else if (d == 8'h80)
                pend = 2'h2;
            else if (d == 8'h25 && mode == 8'h60)
                ucnt = 4'hA;
            else if (d == 8'h90)
                ex = 1'b1;
            else if (ex && d == 8'h00)
            begin
                mode = 8'h00;
                ex = 1'b0;
            end
        end
    end
    // ======================================================================
    // Read data; a released bus shows the inverse value.
    always @*
    begin
        case (mode)
            8'h40: rd = (flash_addr == '0) ? lock : 8'hA5;
            8'h60: rd = (flash_addr[AW-1:3] == '0) ? pwd[flash_addr[2:0]] : 8'hA5;
            8'hC0: rd = {7'h00, ~persistent_protect_bit[sec]};
            8'h50: rd = {7'h00, ~frz};
            8'hE0: rd = {7'h00, ~volatile_protect_bit[sec]};
            default: rd = 8'hFF;
        endcase
        flash_data_in = (!flash_ce_n && !flash_oe_n) ? rd : ~rd;
    end
endmodule // flash_device_model

// ==== verif/testbench.sv ====
// Self-checking testbench of the protection command sequencer.
`timescale 1ns/10ps
`include "protect_cmd_regs.vh"
module testbench;
    localparam AW = 23;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic req = 1'b0;
    logic [3:0] op = 4'h0;
    logic [7:0] mode_code = 8'h00;
    logic [AW-1:0] sa = '0;
    logic [7:0] wr_value = 8'h00;
    logic [63:0] pw = '0;
    wire ready, done_q, protected_q, flash_data_oe_n;
    wire flash_ce_n, flash_we_n, flash_oe_n;
    wire [7:0] rd_value_q, flash_data_out, flash_data_in;
    wire [63:0] password_rd_q;
    wire [AW-1:0] flash_addr;
    int bad_count = 0;
    int n_compared = 0;
    logic [31:0] r = 32'h6BBA55A9;
    logic [AW-1:0] qa[$], ea[$];
    logic [7:0] qd[$], ed[$];
    always #25 clk = ~clk;
    protect_cmd_host #(.AW(AW)) dut_u (.clk(clk), .nrst(nrst), .req(req),
        .op(op), .mode_code(mode_code), .sector_select_address(sa),
        .wr_value(wr_value), .password_byte_value(pw), .ready(ready),
        .done_q(done_q), .rd_value_q(rd_value_q),
        .password_rd_q(password_rd_q), .protected_q(protected_q),
        .flash_addr(flash_addr), .flash_data_out(flash_data_out),
        .flash_data_oe_n(flash_data_oe_n), .flash_data_in(flash_data_in),
        .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
        .flash_oe_n(flash_oe_n));
    flash_device_model #(.AW(AW)) dev_u (.flash_addr(flash_addr),
        .flash_data_out(flash_data_out), .flash_ce_n(flash_ce_n),
        .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
        .flash_data_in(flash_data_in));
    // ======================================================================
    // Helpers.
    always @(posedge flash_we_n)
    begin
        if (flash_ce_n === 1'b0)
        begin
            qa.push_back(flash_addr);
            qd.push_back(flash_data_out);
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic ew(input logic [AW-1:0] a, input logic [7:0] d);
        ea.push_back(a);
        ed.push_back(d);
    endtask
    task automatic cmp(input string nm, input logic [63:0] e,
        input logic [63:0] s);
        n_compared++;
        if (s !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic run(input logic [3:0] o, input logic [AW-1:0] s,
        input logic [7:0] v);
        @(posedge clk);
        req <= 1'b1;
        op <= o;
        sa <= s;
        wr_value <= v;
        mode_code <= v;
        @(posedge clk);
        req <= 1'b0;
        repeat (200)
        begin
            @(posedge clk);
            #1;
            if (done_q === 1'b1)
                break;
        end
        cmp("done", 64'h1, {63'h0, done_q});
        cmp("write count", ea.size(), qa.size());
        foreach (ea[i])
            if (i < qa.size())
            begin
                cmp("write address", ea[i], qa[i]);
                cmp("write data", ed[i], qd[i]);
            end
        ea.delete();
        ed.delete();
        qa.delete();
        qd.delete();
    endtask
    task automatic enter(input logic [7:0] m);
        ew(12'hAAA, 8'hAA);
        ew(12'h555, 8'h55);
        ew(12'hAAA, m);
        run(`OP_ENTER, '0, m);
    endtask
    task automatic leave(input logic rst);
        if (rst)
            ew('0, 8'hF0);
        else
        begin
            ew('0, 8'h90);
            ew('0, 8'h00);
        end
        run(rst ? `OP_RESET : `OP_EXIT, '0, 8'h00);
    endtask
    task automatic stop_test;
        $display("Compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ======================================================================
    // Main sequence.
    initial
    begin
        logic [7:0] v;
        logic [AW-1:0] s;
        logic [63:0] pwv;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        enter(`MODE_LOCK_REG);
        r = lfsr(r);
        v = r[7:0] & 8'h7F;
        ew('0, 8'hA0);
        ew('0, v);
        run(`OP_LOCK_PROG, '0, v);
        run(`OP_LOCK_READ, '0, 8'h00);
        cmp("lock value", v, rd_value_q);
        leave(1'b0);
        enter(`MODE_PASSWORD);
        for (int b = 0; b < 8; b++)
        begin
            r = lfsr(r);
            pwv[8*b +: 8] = r[7:0] & 8'h7F;
            ew('0, 8'hA0);
            ew(AW'(b), pwv[8*b +: 8]);
            run(`OP_PWD_PROG, AW'(b), pwv[8*b +: 8]);
        end
        run(`OP_PWD_READ, '0, 8'h00);
        cmp("password", pwv, password_rd_q);
        pw <= pwv;
        ew('0, 8'h25);
        ew('0, 8'h03);
        for (int b = 0; b < 8; b++)
            ew(AW'(b), pwv[8*b +: 8]);
        ew('0, 8'h29);
        run(`OP_PWD_UNLOCK, '0, 8'h00);
        leave(1'b0);
        enter(`MODE_PERSIST);
        r = lfsr(r);
        s = r[AW-1:0];
        ew(s, 8'hA0);
        ew(s, 8'h00);
        run(`OP_PERSIST_SET, s, 8'h00);
        run(`OP_STATUS_READ, s, 8'h00);
        cmp("persist bit", 64'h1, {63'h0, protected_q});
        ew('0, 8'h80);
        ew('0, 8'h30);
        run(`OP_PERSIST_ERASE, s, 8'h00);
        run(`OP_STATUS_READ, s, 8'h00);
        cmp("persist erased", 64'h0, {63'h0, protected_q});
        leave(1'b1);
        enter(`MODE_FREEZE);
        ew('0, 8'hA0);
        ew('0, 8'h00);
        run(`OP_FREEZE_SET, '0, 8'h00);
        run(`OP_FREEZE_READ, '0, 8'h00);
        cmp("freeze bit", 64'h1, {63'h0, protected_q});
        leave(1'b0);
        enter(`MODE_VOLATILE);
        for (int k = 0; k < 2; k++)
        begin
            ew(s, 8'hA0);
            ew(s, k[7:0]);
            run(k ? `OP_VOL_CLEAR : `OP_VOL_SET, s, 8'h00);
            run(`OP_STATUS_READ, s, 8'h00);
            cmp("volatile bit", 64'(1 - k), {63'h0, protected_q});
        end
        leave(1'b1);
        stop_test;
    end
    initial
    begin
        #2000000;
        bad_count++;
        stop_test;
    end
endmodule // testbench
